// file: fan_duty_cycle_control_test.sv
// self-checking bench of the fan duty control with a behavioural target model
`timescale 1ns/1ns
`default_nettype none
`include "fdc_defs.svh"
module fan_duty_cycle_control_test;
  import fdc_pkg::*;
  logic mclk, rst, reg_wr, reg_rd, remote_fault, local_fault, below, drive, alert_n, tmo_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, step, pd, pv;
  int bad_count, num_checks, seed, k, st, mx, cf, e;

  // ************************************************************
  // clock, host and design
  // ************************************************************
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  fdc_host_model i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // short ramp and spin-up counts keep the run brief
  fdc_fan_duty_ctrl #(.RATE_BASE_CYC(4), .SPINUP_CYC(8)) i_dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .remote_fault(remote_fault), .local_fault(local_fault),
    .temp_below_start(below), .temp_step_duty(step), .fan_drive_output(drive),
    .overheat_alert_n(alert_n), .bus_timeout_en(tmo_en));

  // ************************************************************
  // model and checks
  // ************************************************************
  // expected automatic target: clip start, add steps, cap by clipped maximum
  function automatic int exp_tgt(int s0, int m0, int c0, logic b, int sd);
    int s, c, t;
    s = (s0 > 240) ? 240 : s0;
    c = (m0 > 240) ? 240 : ((m0 < 2) ? 2 : m0);
    if (b) t = c0[3] ? s : 0;
    else t = (s + sd > 240) ? 240 : s + sd;
    return (t > c) ? c : t;
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] a, input int x);
    logic [7:0] d;
    i_host.rd(a, d);
    num_checks++;
    if (d !== x[7:0]) begin
      bad_count++;
      $display("ERROR %0t reg %h got %h exp %h", $time, a, d, x[7:0]);
    end
  endtask

  // sel 0 timeout enable, 1 alert, 2 drive; two cycles let the pin settle
  task automatic chk_pin(input int sel, input logic x);
    logic v;
    repeat (2) @(negedge mclk);
    v = (sel == 0) ? tmo_en : ((sel == 1) ? alert_n : drive);
    num_checks++;
    if (v !== x) begin
      bad_count++;
      $display("ERROR %0t pin %0d got %b exp %b", $time, sel, v, x);
    end
  endtask

  // ramp sample: not below the last read, at most one step of two above it, even, short of the target
  task automatic chk_ramp(input logic [7:0] d, input logic [7:0] p, input int x);
    num_checks++;
    if ($isunknown(d) || d < p || int'(d) > int'(p) + 2 || d[0] || int'(d) >= x) begin
      bad_count++;
      $display("ERROR %0t ramp got %h after %h", $time, d, p);
    end
  endtask

  // bounded poll of the present duty, a miss ends the run
  task automatic wait_present(input int x);
    logic [7:0] d;
    int n;
    d = ~x[7:0];
    for (n = 0; n < 200 && d !== x[7:0]; n++) i_host.rd(`FDC_OFS_PRESENT, d);
    num_checks++;
    if (d !== x[7:0]) begin
      bad_count++;
      $display("ERROR %0t present stuck at %h exp %h", $time, d, x[7:0]);
      end_sim();
    end
  endtask

  // watchdog against a hang anywhere
  initial begin
    #4000000;
    bad_count++;
    $display("ERROR %0t run limit reached", $time);
    end_sim();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rst, remote_fault, local_fault, below, step, bad_count, num_checks} = {1'b1, 3'b000, 8'h00, 64'd0};
    seed = 59142;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    chk_pin(0, 1'b1);
    chk_reg(`FDC_OFS_MASK, 8'h00);
    chk_reg(`FDC_OFS_START, 8'h60);
    chk_reg(`FDC_OFS_MAX, 8'hF0);
    chk_reg(`FDC_OFS_TARGET, 8'h00);
    chk_reg(`FDC_OFS_PRESENT, 8'h00);
    chk_reg(8'h33, 8'h00);
    i_host.wr(`FDC_OFS_CFG, 8'h20);
    chk_pin(0, 1'b0);
    // every mask and fault pairing
    for (k = 0; k < 16; k++) begin
      i_host.wr(`FDC_OFS_MASK, {k[3:2], 6'h00});
      remote_fault = k[1];
      local_fault = k[0];
      chk_pin(1, !((k[1] && !k[3]) || (k[0] && !k[2])));
    end
    // manual mode, immediate rate, spin-up off, low cap that must be ignored
    i_host.wr(`FDC_OFS_RATE, 8'h00);
    i_host.wr(`FDC_OFS_CFG, 8'h04);
    i_host.wr(`FDC_OFS_MAX, 8'h10);
    i_host.wr(`FDC_OFS_TARGET, 8'hFA);
    chk_reg(`FDC_OFS_TARGET, 8'hF0);
    wait_present(8'hF0);
    chk_pin(2, 1'b0);
    i_host.wr(`FDC_OFS_CFG, 8'h14);
    chk_pin(2, 1'b1);
    i_host.wr(`FDC_OFS_TARGET, 8'h00);
    wait_present(8'h00);
    chk_pin(2, 1'b0);
    // fastest stepped ramp: steps of two, never a jump, never spin-up
    i_host.wr(`FDC_OFS_CFG, 8'h04);
    i_host.wr(`FDC_OFS_RATE, 8'h20);
    i_host.wr(`FDC_OFS_TARGET, 8'h20);
    pv = 8'h00;
    for (k = 0; k < 6; k++) begin
      i_host.rd(`FDC_OFS_PRESENT, pd);
      chk_ramp(pd, pv, 8'h20);
      pv = pd;
    end
    wait_present(8'h20);
    // spin-up from zero duty with spin-up enabled
    i_host.wr(`FDC_OFS_RATE, 8'h00);
    i_host.wr(`FDC_OFS_TARGET, 8'h00);
    wait_present(8'h00);
    i_host.wr(`FDC_OFS_CFG, 8'h00);
    i_host.wr(`FDC_OFS_TARGET, 8'h28);
    wait_present(8'hF0);
    wait_present(8'h28);
    // automatic mode on the remote and local channels, random start, cap and steps
    for (k = 0; k < 10; k++) begin
      // both temperature sources in turn; passes 3 and 5 hold start and cap above full scale
      i_host.wr(`FDC_OFS_FANCFG, k[2] ? 8'h10 : 8'h20);
      st = (k == 3 || k == 5) ? 8'hF8 : ($random(seed) & 255);
      mx = (k == 7) ? 8'h01 : ((k == 3 || k == 5) ? 8'hFF : ($random(seed) & 255));
      cf = k[0] ? 8'h0C : 8'h04;
      i_host.wr(`FDC_OFS_START, st[7:0]);
      i_host.wr(`FDC_OFS_MAX, mx[7:0]);
      i_host.wr(`FDC_OFS_CFG, cf[7:0]);
      below = k[1];
      step = $random(seed) & 63;
      e = exp_tgt(st, mx, cf, below, step);
      chk_reg(`FDC_OFS_TARGET, e);
      wait_present(e);
    end
    end_sim();
  end
endmodule // fan_duty_cycle_control_test
`default_nettype wire

// file: fdc_defs.svh
// register offsets, field positions, reset values and timing counts of the fan duty control
`ifndef FDC_DEFS_SVH
`define FDC_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define FDC_OFS_CFG 8'h02
`define FDC_OFS_MASK 8'h06
`define FDC_OFS_START 8'h07
`define FDC_OFS_MAX 8'h08
`define FDC_OFS_TARGET 8'h09
`define FDC_OFS_PRESENT 8'h0A
`define FDC_OFS_FANCFG 8'h0D
`define FDC_OFS_RATE 8'h0E

// ************************************************************
// reset values
// ************************************************************
`define FDC_RST_CFG 8'h00
`define FDC_RST_MASK 8'h00
`define FDC_RST_START 8'h60
`define FDC_RST_MAX 8'hF0
`define FDC_RST_TARGET 8'h00
`define FDC_RST_PRESENT 8'h00
`define FDC_RST_FANCFG 8'h00
`define FDC_RST_RATE 8'hA0

// ************************************************************
// field positions
// ************************************************************
`define FDC_CFG_TIMEOUT 5
`define FDC_CFG_INVERT 4
`define FDC_CFG_MINDUTY 3
`define FDC_CFG_SPINDIS 2
`define FDC_MASK_REMOTE 7
`define FDC_MASK_LOCAL 6
`define FDC_FANCFG_REMOTE 5
`define FDC_FANCFG_LOCAL 4
`define FDC_RATE_HI 7
`define FDC_RATE_LO 5

// ************************************************************
// duty scale and timing
// ************************************************************
`define FDC_DUTY_FULL 8'hF0
`define FDC_DUTY_STEP 8'h02
`define FDC_DUTY_MINCAP 8'h02
`define FDC_CLK_HZ 25000000
`define FDC_RATE_BASE_US 62500
`define FDC_RATE_BASE_CYC ((`FDC_RATE_BASE_US * (`FDC_CLK_HZ / 1000000)))
`define FDC_SPINUP_MS 2000
`define FDC_SPINUP_CYC ((`FDC_SPINUP_MS * (`FDC_CLK_HZ / 1000)))
`define FDC_SLOT_DIV 16'd3156

`endif

// file: fdc_duty_ramp.sv
// duty ramp: moves the actual duty toward the target, with fan spin-up
`timescale 1ns/1ns
`default_nettype none
`include "fdc_defs.svh"
module fdc_duty_ramp
  import fdc_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYC = `FDC_RATE_BASE_CYC,
  parameter int unsigned SPINUP_CYC = `FDC_SPINUP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire fdc_duty_t target,
  input wire logic [2:0] rate_code,
  input wire logic spin_dis,
  output fdc_duty_t duty
);
  // ************************************************************
  // ramp state
  // ************************************************************
  fdc_ramp_st_t st_ff, nxt_st; // run or spin-up
  logic [31:0] cnt_ff, nxt_cnt; // interval or spin-up timer
  fdc_duty_t duty_ff, nxt_duty; // actual duty
  logic [31:0] ivl; // cycles between increments

  // interval doubles with each code step above one
  function automatic logic [31:0] fdc_interval(input logic [2:0] code);
    fdc_interval = 32'(RATE_BASE_CYC) << (code - 3'd1);
  endfunction

  // next state, timer and duty
  always_comb begin
    ivl = fdc_interval(rate_code);
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_duty = duty_ff;
    case (st_ff)
      FDC_RUN: begin
        if (!spin_dis && duty_ff == 8'h00 && target != 8'h00) begin
          nxt_st = FDC_SPIN;
          nxt_cnt = 32'h0000_0000;
          nxt_duty = `FDC_DUTY_FULL;
        end else if (rate_code == 3'b000) begin
          nxt_cnt = 32'h0000_0000;
          nxt_duty = target;
        end else if (cnt_ff >= ivl - 32'h0000_0001) begin
          nxt_cnt = 32'h0000_0000;
          if (duty_ff < target) begin
            nxt_duty = (target - duty_ff < `FDC_DUTY_STEP) ? target : duty_ff + `FDC_DUTY_STEP;
          end else if (duty_ff > target) begin
            nxt_duty = (duty_ff - target < `FDC_DUTY_STEP) ? target : duty_ff - `FDC_DUTY_STEP;
          end
        end else begin
          nxt_cnt = cnt_ff + 32'h0000_0001;
        end
      end
      FDC_SPIN: begin
        // full drive until the spin-up time has run out, then jump to target
        nxt_cnt = cnt_ff + 32'h0000_0001;
        if (cnt_ff >= 32'(SPINUP_CYC) - 32'h0000_0001) begin
          nxt_st = FDC_RUN;
          nxt_cnt = 32'h0000_0000;
          nxt_duty = target;
        end
      end
      default: begin
        nxt_st = FDC_RUN;
        nxt_cnt = 32'h0000_0000;
        nxt_duty = 8'h00;
      end
    endcase
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= FDC_RUN;
      cnt_ff <= 32'h0000_0000;
      duty_ff <= `FDC_RST_PRESENT;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      duty_ff <= nxt_duty;
    end
  end

  assign duty = duty_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_spin_start;
    st_ff == FDC_RUN && !spin_dis && duty_ff == 8'h00 && target != 8'h00;
  endsequence
  spin_full_a: assert property (s_spin_start |=> st_ff == FDC_SPIN && duty_ff == `FDC_DUTY_FULL)
    else $error("spin-up not at full duty");
  instant_set_a: assert property (st_ff == FDC_RUN && rate_code == 3'b000
    && (spin_dis || duty_ff != 8'h00 || target == 8'h00) |=> duty_ff == $past(target))
    else $error("immediate change missed");
  step_two_a: assert property (st_ff == FDC_RUN && $past(st_ff) == FDC_RUN && $past(rate_code) != 3'b000
    |-> (duty_ff - $past(duty_ff) <= 8'h02) || ($past(duty_ff) - duty_ff <= 8'h02))
    else $error("ramp step above two");
endmodule // fdc_duty_ramp
`default_nettype wire

// file: fdc_fan_duty_ctrl.sv
// fan duty control: registers, target derivation, alert masking, ramp and pwm
`timescale 1ns/1ns
`default_nettype none
`include "fdc_defs.svh"

// Functional notes
// - config bit 5 zero enables bus timeout
// - config bit 4 sets full-duty output level
// - bit 3 clear: zero duty below threshold
// - bit 3 set: start duty below threshold
// - config bit 2 set skips spin-up
// - mask bit 7 blocks remote alert
// - mask bit 6 blocks local alert
// - alert mask resets to zero
// - start duty above 240 means full
// - start duty resets to 60h
// - maximum duty caps automatic duty, 2..240
// - maximum duty resets to F0h
// - manual mode ignores maximum duty
// - automatic target register holds computed duty
// - nonzero rate ramps duty gradually
// - manual target written by software is used
// - target duty resets to zero
// - present duty reads driven duty, resets zero
// - fan config 5 and 4 zero: manual
// - manual target above 240 clipped
// - rate field sets step interval, 000 immediate
module fdc_fan_duty_ctrl
  import fdc_pkg::*;
#(
  parameter int unsigned RATE_BASE_CYC = `FDC_RATE_BASE_CYC,
  parameter int unsigned SPINUP_CYC = `FDC_SPINUP_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr, // register offset from the bus engine
  input wire logic reg_wr, // one-cycle write strobe
  input wire logic [7:0] reg_wdata, // write byte
  input wire logic reg_rd, // one-cycle read strobe
  output logic [7:0] reg_rdata, // read byte, valid the cycle after reg_rd
  input wire logic remote_fault, // remote channel over limit
  input wire logic local_fault, // local channel over limit
  input wire logic temp_below_start, // temperature below fan-start threshold
  input wire logic [7:0] temp_step_duty, // duty added above start by temperature steps
  output logic fan_drive_output, // pwm drive
  output logic overheat_alert_n, // alert, low when asserted
  output logic bus_timeout_en // bus engine timeout enable
);
  // ************************************************************
  // helpers
  // ************************************************************

  // values above full duty read as full duty
  function automatic fdc_duty_t fdc_clip240(input fdc_duty_t v);
    fdc_clip240 = (v > `FDC_DUTY_FULL) ? `FDC_DUTY_FULL : v;
  endfunction

  // saturating add limited to full duty
  function automatic fdc_duty_t fdc_add240(input fdc_duty_t a, input fdc_duty_t b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    fdc_add240 = (s > {1'b0, `FDC_DUTY_FULL}) ? `FDC_DUTY_FULL : s[7:0];
  endfunction

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] cfg_ff, nxt_cfg; // configuration byte
  logic [7:0] mask_ff, nxt_mask; // alert channel mask
  logic [7:0] start_ff, nxt_start; // fan-start duty
  logic [7:0] max_ff, nxt_max; // maximum duty
  logic [7:0] fancfg_ff, nxt_fancfg; // fan configuration
  logic [7:0] rate_ff, nxt_rate; // rate of change
  logic [7:0] target_ff, nxt_target; // target duty
  logic [7:0] rdata_ff, nxt_rdata; // read data
  logic auto_mode; // either temperature source selected
  fdc_duty_t auto_target; // target from temperature
  fdc_duty_t present_duty; // duty now on the output

  // write decode and target register update
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_mask = mask_ff;
    nxt_start = start_ff;
    nxt_max = max_ff;
    nxt_fancfg = fancfg_ff;
    nxt_rate = rate_ff;
    nxt_target = target_ff;
    if (reg_wr) begin
      case (reg_addr)
        // bits 7:6 are stored as written; keeping them zero is up to software
        `FDC_OFS_CFG: nxt_cfg = reg_wdata;
        `FDC_OFS_MASK: nxt_mask = reg_wdata;
        `FDC_OFS_START: nxt_start = reg_wdata;
        `FDC_OFS_MAX: nxt_max = reg_wdata;
        `FDC_OFS_FANCFG: nxt_fancfg = reg_wdata;
        `FDC_OFS_RATE: nxt_rate = reg_wdata;
        `FDC_OFS_TARGET: nxt_target = fdc_clip240(reg_wdata);
        // present duty and unmapped offsets ignore writes
        default: begin
        end
      endcase
    end
    // hardware owns the target in automatic mode
    if (auto_mode) begin
      nxt_target = auto_target;
    end
  end

  // register storage, power-on values
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_ff <= `FDC_RST_CFG;
      mask_ff <= `FDC_RST_MASK;
      start_ff <= `FDC_RST_START;
      max_ff <= `FDC_RST_MAX;
      fancfg_ff <= `FDC_RST_FANCFG;
      rate_ff <= `FDC_RST_RATE;
      target_ff <= `FDC_RST_TARGET;
    end else begin
      cfg_ff <= nxt_cfg;
      mask_ff <= nxt_mask;
      start_ff <= nxt_start;
      max_ff <= nxt_max;
      fancfg_ff <= nxt_fancfg;
      rate_ff <= nxt_rate;
      target_ff <= nxt_target;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************

  // read mux; the byte is latched so the bus engine sees a stable value
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        `FDC_OFS_CFG: nxt_rdata = cfg_ff;
        `FDC_OFS_MASK: nxt_rdata = mask_ff;
        `FDC_OFS_START: nxt_rdata = start_ff;
        `FDC_OFS_MAX: nxt_rdata = max_ff;
        `FDC_OFS_TARGET: nxt_rdata = target_ff;
        `FDC_OFS_PRESENT: nxt_rdata = present_duty;
        `FDC_OFS_FANCFG: nxt_rdata = fancfg_ff;
        `FDC_OFS_RATE: nxt_rdata = rate_ff;
        // offsets outside this block answer zero
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ************************************************************
  // automatic target derivation
  // ************************************************************
  fdc_duty_t start_c; // start duty within scale
  fdc_duty_t max_c; // cap within 2..240
  fdc_duty_t raw_duty; // duty before the cap

  // target from threshold state, start duty and temperature steps
  always_comb begin
    // both source bits clear selects manual
    auto_mode = fancfg_ff[`FDC_FANCFG_REMOTE] | fancfg_ff[`FDC_FANCFG_LOCAL];
    start_c = fdc_clip240(start_ff);
    max_c = fdc_clip240(max_ff);
    if (max_c < `FDC_DUTY_MINCAP) begin
      max_c = `FDC_DUTY_MINCAP;
    end
    if (temp_below_start) begin
      raw_duty = cfg_ff[`FDC_CFG_MINDUTY] ? start_c : 8'h00;
    end else begin
      // rises from the start duty as the temperature climbs
      raw_duty = fdc_add240(start_c, temp_step_duty);
    end
    auto_target = (raw_duty > max_c) ? max_c : raw_duty;
  end

  // ************************************************************
  // duty ramp and waveform
  // ************************************************************

  fdc_duty_ramp #(
    .RATE_BASE_CYC(RATE_BASE_CYC),
    .SPINUP_CYC(SPINUP_CYC)
  ) u_ramp (
    .mclk(mclk),
    .rst(rst),
    .target(target_ff),
    .rate_code(rate_ff[`FDC_RATE_HI:`FDC_RATE_LO]),
    .spin_dis(cfg_ff[`FDC_CFG_SPINDIS]),
    .duty(present_duty)
  );

  // output waveform with programmable polarity
  fdc_pwm_gen u_pwm (
    .mclk(mclk),
    .rst(rst),
    .duty(present_duty),
    .invert(cfg_ff[`FDC_CFG_INVERT]),
    .pwm_out(fan_drive_output)
  );

  // ************************************************************
  // alert and timeout outputs
  // ************************************************************
  logic alert_n_ff, nxt_alert_n; // registered alert level
  logic tmo_ff, nxt_tmo; // registered timeout enable

  // masked fault merge; timeout is the inverse of its disable bit
  always_comb begin
    nxt_alert_n = ~((remote_fault & ~mask_ff[`FDC_MASK_REMOTE]) |
                    (local_fault & ~mask_ff[`FDC_MASK_LOCAL]));
    nxt_tmo = ~cfg_ff[`FDC_CFG_TIMEOUT];
  end

  // output registers; alert idles released after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alert_n_ff <= 1'b1;
      tmo_ff <= 1'b1;
    end else begin
      alert_n_ff <= nxt_alert_n;
      tmo_ff <= nxt_tmo;
    end
  end

  assign overheat_alert_n = alert_n_ff;
  assign bus_timeout_en = tmo_ff;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  mask_remote_a: assert property (mask_ff[7] && !local_fault |=> overheat_alert_n)
    else $error("masked remote fault raised alert");
  mask_local_a: assert property (mask_ff[6] && !remote_fault |=> overheat_alert_n)
    else $error("masked local fault raised alert");
  alert_live_a: assert property (remote_fault && !mask_ff[7] |=> !overheat_alert_n)
    else $error("unmasked remote fault lost");
  timeout_a: assert property (##1 bus_timeout_en == !$past(cfg_ff[5]))
    else $error("timeout enable wrong");
  manual_clip_a: assert property (!auto_mode && reg_wr && reg_addr == 8'h09 && reg_wdata > 8'hF0
    ##1 !auto_mode |-> target_ff == 8'hF0) else $error("manual target not clipped");
  manual_raw_a: assert property (!auto_mode && reg_wr && reg_addr == 8'h09 && reg_wdata <= 8'hF0
    ##1 !auto_mode |-> target_ff == $past(reg_wdata)) else $error("manual target altered");
  auto_cap_a: assert property (auto_mode |=> target_ff <= 8'hF0 &&
    (target_ff <= $past(max_ff) || $past(max_ff) < 8'h02)) else $error("auto target over cap");
  min_zero_a: assert property (auto_mode && temp_below_start && !cfg_ff[3] |=> target_ff == 8'h00)
    else $error("below threshold not zero");
  min_start_a: assert property (auto_mode && temp_below_start && cfg_ff[3] && max_ff == 8'hF0
    |=> target_ff == fdc_clip240($past(start_ff))) else $error("below threshold not start duty");
  present_rd_a: assert property (reg_rd && reg_addr == 8'h0A |=> reg_rdata == $past(present_duty))
    else $error("present duty read wrong");

  // ************************************************************
  // alert, hold and full-scale checks
  // ************************************************************
  local_live_a: assert property (local_fault && !mask_ff[6] |=> !overheat_alert_n)
    else $error("unmasked local fault lost");
  alert_idle_a: assert property (!remote_fault && !local_fault |=> overheat_alert_n)
    else $error("alert raised without fault");
  start_full_a: assert property (auto_mode && temp_below_start && cfg_ff[3] && start_ff > 8'hF0
    && max_ff >= 8'hF0 |=> target_ff == 8'hF0) else $error("start above full not full");
  auto_max_a: assert property (auto_mode && !temp_below_start && max_ff > 8'hF0 && start_ff >= 8'hF0
    |=> target_ff == 8'hF0) else $error("cap above full not full");
  manual_hold_a: assert property (!auto_mode && !(reg_wr && reg_addr == 8'h09)
    |=> target_ff == $past(target_ff)) else $error("manual target changed unasked");
  rd_hold_a: assert property (!reg_rd |=> reg_rdata == $past(reg_rdata))
    else $error("read byte changed without read");
endmodule // fdc_fan_duty_ctrl
`default_nettype wire

// file: fdc_host_model.sv
// bus host model: drives the register strobes of the fan duty control
`timescale 1ns/1ns
`default_nettype none
`include "fdc_defs.svh"
module fdc_host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ************************************************************
  // idle levels
  // ************************************************************
  // strobes low from time zero, data lines hold a neutral pattern
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // ************************************************************
  // bus cycles
  // ************************************************************
  // one write byte; strobe stands for exactly one edge
  // reserved config bits 7:6 zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = (a == `FDC_OFS_CFG) ? (d & 8'h3F) : d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // released data flips so a stale byte never looks valid
    reg_wdata = ~reg_wdata;
  endtask

  // one read byte; answer is registered on the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
endmodule // fdc_host_model
`default_nettype wire

// file: fdc_pkg.sv
// types shared by the fan duty control modules
`default_nettype none
package fdc_pkg;
  // duty value, 240 is full duty
  typedef logic [7:0] fdc_duty_t;
  // ramp controller states
  typedef enum logic [1:0] {FDC_RUN, FDC_SPIN} fdc_ramp_st_t;
endpackage
`default_nettype wire

// file: fdc_pwm_gen.sv
// pwm waveform generator: 240 slots per period compared against the duty
`timescale 1ns/1ns
`default_nettype none
`include "fdc_defs.svh"
module fdc_pwm_gen
  import fdc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire fdc_duty_t duty,
  input wire logic invert,
  output logic pwm_out
);
  // ************************************************************
  // slot timing
  // ************************************************************
  logic [15:0] div_ff, nxt_div; // clocks per slot
  logic [7:0] slot_ff, nxt_slot; // slot within the period
  logic pwm_ff, nxt_pwm; // registered drive level
  logic active; // slot is inside the duty window

  // next slot counter, output polarity
  always_comb begin
    nxt_div = div_ff + 16'h0001;
    nxt_slot = slot_ff;
    if (div_ff == `FDC_SLOT_DIV - 16'h0001) begin
      nxt_div = 16'h0000;
      nxt_slot = (slot_ff == `FDC_DUTY_FULL - 8'h01) ? 8'h00 : slot_ff + 8'h01;
    end
    active = (slot_ff < duty);
    nxt_pwm = invert ? active : ~active;
  end

  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_ff <= 16'h0000;
      slot_ff <= 8'h00;
      pwm_ff <= 1'b1;
    end else begin
      div_ff <= nxt_div;
      slot_ff <= nxt_slot;
      pwm_ff <= nxt_pwm;
    end
  end

  assign pwm_out = pwm_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  slot_range_a: assert property (slot_ff < `FDC_DUTY_FULL) else $error("slot past 239");
  full_low_a: assert property ($past(duty) >= `FDC_DUTY_FULL && !$past(invert) |-> !pwm_ff)
    else $error("full duty not low");
  full_high_a: assert property ($past(duty) >= `FDC_DUTY_FULL && $past(invert) |-> pwm_ff)
    else $error("full duty not high");
  zero_idle_a: assert property ($past(duty) == 8'h00 |-> pwm_ff == !$past(invert))
    else $error("zero duty drove active");
endmodule // fdc_pwm_gen
`default_nettype wire
